// file: pkg/ricm_pkg.sv
package ricm_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 25000000;
  // Contactor drop-out window after outputs go off, in ms
  localparam int FB_DROP_MS = 300;
  localparam int FB_DROP_CYC = (CLK_HZ / 1000) * FB_DROP_MS;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

  // ************************************************************
  // Error codes on the indicator
  // ************************************************************
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_FEEDBACK = 4'h1;
  localparam logic [3:0] ERR_LOCKOUT = 4'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic interlock_en;  // Internal restart interlock active
    logic feedback_en;   // Contactor feedback check enabled
  } ricm_cfg_t;

  typedef struct packed {
    logic red;
    logic green;
    logic yellow;        // Reset required
    logic [3:0] err_code;
  } ricm_ind_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_RESET,
    ST_ON,
    ST_FB_ERROR,
    ST_LOCKOUT
  } ricm_state_t;

endpackage

// file: src/ricm_sync.sv
// ************************************************************
// Three-stage input synchroniser with agreement filter
// ************************************************************
module ricm_sync (
  input wire logic sys_clk,  // System clock
  input wire logic rst,      // Async reset, active high
  input wire logic din,      // Asynchronous input
  output logic dout          // Filtered synchronous level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ricm_sync_st_t;

  ricm_sync_st_t st;
  ricm_sync_st_t next_st;

  // Level changes once stages two and three agree; s1 feeds only s2
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;

endmodule // ricm_sync

// file: src/ricm_top.sv
module ricm_top (
  input wire logic sys_clk,                        // System clock, 25 MHz
  input wire logic rst,                            // Async reset, active high
  input wire logic path_clear,                     // Light path clear, same domain
  input wire ricm_pkg::ricm_cfg_t cfg,             // Static configuration
  input wire logic reset_button,                   // Reset button pin, async
  input wire logic contactor_closed,               // Contactor feedback pin, async
  output logic safety_switching_output,            // Safety output, high = on
  output ricm_pkg::ricm_ind_t ind                  // Indicator state
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Both pins are asynchronous and filtered alike; bit 0 button, bit 1 feedback
  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  logic btn_s;
  logic fb_s;

  // Pins gathered so one loop serves both
  assign pin_raw = {contactor_closed, reset_button};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      // One filter per pin; no stage is shared between pins
      ricm_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(pin_raw[gi]),
        .dout(pin_s[gi])
      );
    end
  endgenerate

  // Filtered levels under their own names
  assign btn_s = pin_s[0];
  assign fb_s = pin_s[1];

  // ************************************************************
  // Indicator decoding
  // ************************************************************
  // Error code shown for a state; every other state shows none
  function automatic logic [3:0] err_of(input ricm_pkg::ricm_state_t s);
    if (s == ricm_pkg::ST_LOCKOUT) begin
      return ricm_pkg::ERR_LOCKOUT;
    end else if (s == ricm_pkg::ST_FB_ERROR) begin
      return ricm_pkg::ERR_FEEDBACK;
    end
    return ricm_pkg::ERR_NONE;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ricm_pkg::ricm_state_t fsm;
    logic btn_prev;
    logic [ricm_pkg::CNT_W-1:0] drop_cnt;  // Drop-out window counter
    logic checked;                          // Contactors seen dropped since break
    logic out;
    ricm_pkg::ricm_ind_t ind;
  } ricm_st_t;

  ricm_st_t st;
  ricm_st_t next_st;
  logic press;

  // Release edge of the button counts, so a stuck button cannot restart
  assign press = st.btn_prev & ~btn_s;

  // Main sequencing
  // Limitation: the drop-out window is long, so a welded contactor
  // reaches lock-out only after a full window spent in the error state.
  // Trade-off: a slow contactor is tolerated rather than tripping at once.
  always_comb begin
    next_st = st;
    next_st.btn_prev = btn_s;
    if (st.drop_cnt != ricm_pkg::CNT_ZERO) begin
      next_st.drop_cnt = st.drop_cnt - 24'h000001;
    end
    if (!fb_s) begin
      next_st.checked = 1'b1;
    end
    unique case (st.fsm)
      ricm_pkg::ST_OFF: begin
        next_st.out = 1'b0;
        // Break in progress: contactors must drop in the window
        if (cfg.feedback_en && st.drop_cnt == 24'h000001 && !st.checked) begin
          next_st.fsm = ricm_pkg::ST_FB_ERROR;
        end else if (path_clear) begin
          if (cfg.interlock_en) begin
            next_st.fsm = ricm_pkg::ST_WAIT_RESET;
          end else if (!cfg.feedback_en || (!fb_s && st.drop_cnt == ricm_pkg::CNT_ZERO)) begin
            next_st.fsm = ricm_pkg::ST_ON;
            next_st.out = 1'b1;
          end
        end
      end
      ricm_pkg::ST_WAIT_RESET: begin
        next_st.out = 1'b0;
        if (!path_clear) begin
          next_st.fsm = ricm_pkg::ST_OFF;
        end else if (cfg.feedback_en && st.drop_cnt == 24'h000001 && !st.checked) begin
          next_st.fsm = ricm_pkg::ST_FB_ERROR;
        end else if (press) begin
          // Pre-restart check: contactors must read open now
          if (cfg.feedback_en && fb_s) begin
            next_st.fsm = ricm_pkg::ST_FB_ERROR;
          end else begin
            next_st.fsm = ricm_pkg::ST_ON;
            next_st.out = 1'b1;
          end
        end
      end
      ricm_pkg::ST_ON: begin
        if (!path_clear) begin
          next_st.fsm = ricm_pkg::ST_OFF;
          next_st.out = 1'b0;
          // Contactor already open in the break cycle still counts as dropped
          next_st.checked = ~fb_s;
          next_st.drop_cnt = ricm_pkg::CNT_W'(ricm_pkg::FB_DROP_CYC);
        end
      end
      ricm_pkg::ST_FB_ERROR: begin
        next_st.out = 1'b0;
        // Contactor still closed with outputs off: no safe state reachable
        if (fb_s && st.drop_cnt == ricm_pkg::CNT_ZERO) begin
          next_st.fsm = ricm_pkg::ST_LOCKOUT;
        end else if (press && path_clear && !fb_s) begin
          next_st.fsm = ricm_pkg::ST_OFF;
        end
      end
      ricm_pkg::ST_LOCKOUT: begin
        next_st.out = 1'b0;
      end
      // Unused codes fall to the safest state
      default: begin
        next_st.fsm = ricm_pkg::ST_LOCKOUT;
        next_st.out = 1'b0;
      end
    endcase
    // Error entry restarts the window that gates lock-out
    if (next_st.fsm == ricm_pkg::ST_FB_ERROR && st.fsm != ricm_pkg::ST_FB_ERROR) begin
      next_st.drop_cnt = ricm_pkg::CNT_W'(ricm_pkg::FB_DROP_CYC);
    end
    next_st.ind.green = next_st.out;
    next_st.ind.red = ~next_st.out;
    next_st.ind.yellow = (next_st.fsm == ricm_pkg::ST_WAIT_RESET);
    next_st.ind.err_code = err_of(next_st.fsm);
  end

  // State register; starts off, interlocked path assumed broken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{fsm: ricm_pkg::ST_OFF, btn_prev: 1'b0, drop_cnt: '0, checked: 1'b1, out: 1'b0,
              ind: '{red: 1'b1, green: 1'b0, yellow: 1'b0, err_code: ricm_pkg::ERR_NONE}};
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Outputs straight from flip-flops, so no glitch reaches the contactors
  assign safety_switching_output = st.out;
  assign ind = st.ind;

endmodule // ricm_top

// file: tb/ricm_chk.sv
module ricm_chk (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic path_clear, // Path
  input wire ricm_pkg::ricm_cfg_t cfg, // Config
  input wire logic reset_button, // Button
  input wire logic contactor_closed, // Feedback
  input wire logic safety_switching_output, // Output
  input wire ricm_pkg::ricm_ind_t ind // Indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pressed;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Each restart must own its press, so the memory drops while on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) pressed <= 1'b0;
    else if (safety_switching_output) pressed <= 1'b0;
    else if (reset_button) pressed <= 1'b1;
  end
  sequence s_break;
    safety_switching_output && !path_clear;
  endsequence
  break_cut_a: assert property (s_break |=> !safety_switching_output)
    else $error("output held after break");
  press_needed_a: assert property ($rose(safety_switching_output) && cfg.interlock_en |-> pressed)
    else $error("output on without press");
  green_on_a: assert property (safety_switching_output |-> ind.green && !ind.red)
    else $error("on without green");
  red_off_a: assert property (!safety_switching_output |-> ind.red && !ind.green)
    else $error("off without red");
  yellow_off_a: assert property (ind.yellow |-> !safety_switching_output)
    else $error("on while reset required");
  err_off_a: assert property (ind.err_code != ricm_pkg::ERR_NONE |-> !safety_switching_output)
    else $error("on with error");
  lockout_hold_a: assert property (ind.err_code == ricm_pkg::ERR_LOCKOUT |=> ind.err_code == ricm_pkg::ERR_LOCKOUT)
    else $error("lock-out left");
  fb_restart_a: assert property ($rose(safety_switching_output) && cfg.feedback_en |-> !$past(contactor_closed, 4))
    else $error("restart with contactor closed");
endmodule // ricm_chk
bind ricm_top ricm_chk u_ricm_chk (.sys_clk, .rst, .path_clear, .cfg, .reset_button, .contactor_closed,
  .safety_switching_output, .ind);

// file: tb/ricm_contactor.sv
module ricm_contactor (
  input wire logic sys_clk, // Clock
  input wire logic drive, // Coil
  input wire logic weld, // Weld fault
  input wire logic restart_button, // Machine button
  output logic contactor_closed, // Feedback
  output logic machine_run // Motion
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] coil;
  // Slow drop-out, a weld keeps contacts shut
  always_ff @(posedge sys_clk) begin
    coil <= {coil[0], drive};
    contactor_closed <= weld | coil[1];
  end
  // Machine runs only on its own button after the output is on
  always_ff @(posedge sys_clk) begin
    if (!drive) machine_run <= 1'b0;
    else if (restart_button) machine_run <= 1'b1;
  end
endmodule // ricm_contactor

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, path_clear = 1'b0, reset_button = 1'b0, weld = 1'b0, restart_button = 1'b0;
  ricm_pkg::ricm_cfg_t cfg = 2'h2;
  logic contactor_closed, safety_switching_output, machine_run;
  ricm_pkg::ricm_ind_t ind;
  int miscompares = 0, compares = 0;
  logic [31:0] seed = 32'h00003318;
  ricm_top u_ricm_top (.sys_clk, .rst, .path_clear, .cfg, .reset_button, .contactor_closed,
    .safety_switching_output, .ind);
  ricm_contactor u_ricm_contactor (.sys_clk, .drive(safety_switching_output), .weld, .restart_button,
    .contactor_closed, .machine_run);
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Expected indicator from output, reset-required and error
  function automatic logic [7:0] exp_ind(input logic on, input logic yel, input logic [3:0] err);
    return {1'b0, ~on, on, yel, err};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic state(input logic on, input logic yel);
    chk("output", {7'h00, on}, {7'h00, safety_switching_output});
    chk("indicator", exp_ind(on, yel, ricm_pkg::ERR_NONE), {1'b0, ind});
  endtask
  // Held past the filter; the release is what counts
  task automatic press();
    seed = xs(seed);
    reset_button = 1'b1;
    cyc(5 + seed[1:0]);
    reset_button = 1'b0;
    cyc(10);
  endtask
  task automatic restart(input ricm_pkg::ricm_cfg_t c);
    rst = 1'b1;
    cfg = c;
    cyc(4);
    rst = 1'b0;
    cyc(3);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Interlock, breaks, feedback and weld in turn
  initial begin
    restart(2'h2);
    state(1'b0, 1'b0);
    path_clear = 1'b1;
    cyc(4);
    state(1'b0, 1'b1);
    press();
    state(1'b1, 1'b0);
    chk("run", 8'h00, {7'h00, machine_run});
    restart_button = 1'b1;
    cyc(2);
    restart_button = 1'b0;
    chk("run", 8'h01, {7'h00, machine_run});
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      path_clear = 1'b0;
      cyc(1);
      chk("cut", 8'h00, {7'h00, safety_switching_output});
      cyc(seed[3:0]);
      press();
      state(1'b0, 1'b0);
      path_clear = 1'b1;
      cyc(20 + seed[7:4]);
      state(1'b0, 1'b1);
      press();
      state(1'b1, 1'b0);
    end
    restart(2'h0);
    state(1'b1, 1'b0);
    path_clear = 1'b0;
    cyc(2);
    path_clear = 1'b1;
    cyc(4);
    state(1'b1, 1'b0);
    restart(2'h3);
    press();
    state(1'b1, 1'b0);
    path_clear = 1'b0;
    cyc(4);
    path_clear = 1'b1;
    press();
    state(1'b1, 1'b0);
    weld = 1'b1;
    restart(2'h3);
    press();
    chk("error", {4'h0, ricm_pkg::ERR_FEEDBACK}, {4'h0, ind.err_code});
    press();
    chk("output", 8'h00, {7'h00, safety_switching_output});
    end_of_test();
  end
endmodule // tb_top
